// file: actt_top.sv
// conversion trigger timing engine with its sample buffer fifo
// assumes strobes, pins and timebase ticks are synchronous to i_core_clk
`timescale 1ns/100ps

module actt_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  // fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  logic         full;
  logic         empty;

  assign empty = (wr_r == rd_r);
  assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge i_core_clk) begin
    if (i_in_valid && !full) begin
      mem[wr_r[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (i_in_valid && !full) begin
        wr_r <= wr_r + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

// Operation
// - each accepted conversion strobe starts one conversion; strobe edge selectable
// - internal strobe: down-counter starts on sample strobe, fires at zero, reloads
// - conversion strobe source: internal divider, counter, pins, lines, star, analog
// - conversion strobe driven active low on any pin or line; pins reset as inputs
// - sample-to-first-conversion delay programmable, three timebase ticks by default
// - sample and conversion strobes ignored until the start trigger arrives
// - further sample strobes ignored until all conversions of the sample done
// - conversion strobes ignored outside a sample and after its count is reached
// - one external signal may drive both strobes, one conversion per edge
// - conversion timebase is sample timebase or 20 MHz tick, never driven out
// - hold-done pulse after each conversion start, polarity and route selectable
// - acquisition begins on start trigger, or on software command without triggers
// - finite ends on sample count or reference trigger; continuous on software stop
// - digital start trigger source and edge selectable
// - analog start source starts on first rising comparison edge
// - start trigger driven out as an active-high pulse
// - posttrigger count equals buffer size minus pretrigger count
// - reference trigger ignored before pretrigger samples are captured
// - waiting for reference with full buffer, oldest sample is overwritten
// - after reference, exactly posttrigger samples are stored, then stop
// - reference source and edge selectable; analog stops on rising comparison edge
// - pause is level sensitive, active level programmable, halts internal sample strobe
// - each sample converts every channel; conversions per sample equal channel count
// - start loads pretrigger count, decrements per sample, then reloads posttrigger
module actt_top import actt_pkg::*; #(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  // configuration and software commands
  input  wire actt_cfg_type        i_cfg,
  input  wire logic                i_sw_start,
  input  wire logic                i_sw_stop,
  // external sources and timebase ticks
  input  wire logic [NUM_FPIN-1:0] i_fpin,
  input  wire logic [NUM_SIL-1:0]  i_sil,
  input  wire logic                i_star,
  input  wire logic                i_acmp,
  input  wire logic                i_ctr_out,
  input  wire logic                i_samp_tb_tick,
  input  wire logic                i_tb20_tick,
  // pin drive
  output logic [NUM_FPIN-1:0]      o_fpin_out,
  output logic [NUM_FPIN-1:0]      o_fpin_oe,
  output logic [NUM_SIL-1:0]       o_sil_out,
  output logic [NUM_SIL-1:0]       o_sil_oe,
  // converter side
  output logic                     o_conv_start,
  output logic [CH_W-1:0]          o_chan,
  output logic                     o_hold_done,
  input  wire logic                i_adc_valid,
  input  wire logic [DATA_W-1:0]   i_adc_data,
  output logic                     o_adc_ready,
  // sample stream out
  output logic                     o_dout_valid,
  output logic [DATA_W-1:0]        o_dout_data,
  input  wire logic                i_dout_ready,
  // status
  output logic                     o_running,
  output logic                     o_armed,
  output logic                     o_start_pulse,
  output logic                     o_done
);
  typedef enum logic [5:0] {
    A_IDLE  = 6'b000001,
    A_RUN   = 6'b000010,
    A_PRE   = 6'b000100,
    A_ARM   = 6'b001000,
    A_POST  = 6'b010000,
    A_DRAIN = 6'b100000
  } actt_acq_type;

  typedef enum logic [1:0] {
    C_WAIT = 2'b01,
    C_CONV = 2'b10
  } actt_conv_type;

  function automatic logic pick(input logic [NUM_SRC-1:0] v, input logic [SEL_W-1:0] code);
    pick = (32'(code) < NUM_SRC) ? v[code] : 1'b0;
  endfunction

  function automatic logic edge_of(input logic cur, input logic prev, input logic rise,
                                   input logic [SEL_W-1:0] code);
    logic r;
    r = rise || (code == SRC_ACMP);
    edge_of = r ? (cur && !prev) : (!cur && prev);
  endfunction

  actt_acq_type           acq_r;
  actt_conv_type          cst_r;
  logic [NUM_SRC-1:0]     raw;
  logic [NUM_SRC-1:0]     sync1_r;
  logic [NUM_SRC-1:0]     sync2_r;
  logic [NUM_SRC-1:0]     prev_samp_r;
  logic [3:0]             lvl;
  logic [3:0]             prev_r;
  logic                   samp_ext_ev;
  logic                   conv_ext_ev;
  logic                   start_ev;
  logic                   ref_ev;
  logic                   paused;
  logic                   running;
  logic                   samp_int_r;
  logic [DIV_W-1:0]       samp_cnt_r;
  logic                   samp_ev;
  logic                   samp_acc;
  logic                   conv_tb;
  logic                   conv_int;
  logic [DIV_W-1:0]       cdiv_r;
  logic [DIV_W-1:0]       delay_eff;
  logic                   int_fire;
  logic                   conv_fire;
  logic [CH_W-1:0]        nchan;
  logic [CH_W-1:0]        left_r;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       post_cnt;
  logic                   fifo_full_n;
  logic                   fifo_valid;
  logic                   discard;
  logic [NUM_LINE-1:0]    pin_out_r;
  logic [NUM_LINE-1:0]    pin_oe_r;

  // first stage feeds only the second
  assign raw = {i_ctr_out, i_acmp, i_star, i_sil, i_fpin};
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  assign lvl = {pick(sync2_r, i_cfg.pause_src), pick(sync2_r, i_cfg.ref_src),
                pick(sync2_r, i_cfg.start_src), pick(sync2_r, i_cfg.conv_src)};
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= lvl;
    end
  end

  // a source switch while running can look like an edge; reconfigure only when idle
  assign conv_ext_ev = edge_of(lvl[0], prev_r[0], i_cfg.conv_rise, i_cfg.conv_src);
  assign samp_ext_ev = edge_of(pick(sync2_r, i_cfg.samp_src), pick({NUM_SRC{1'b0}} | prev_samp_r,
                               i_cfg.samp_src), i_cfg.samp_rise, i_cfg.samp_src);
  assign start_ev = (i_cfg.start_src == SRC_SOFT) ? i_sw_start
                  : edge_of(lvl[1], prev_r[1], i_cfg.start_rise, i_cfg.start_src);
  assign ref_ev = i_cfg.ref_en && edge_of(lvl[2], prev_r[2], i_cfg.ref_rise, i_cfg.ref_src);
  assign paused = i_cfg.pause_en && (lvl[3] == i_cfg.pause_high);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prev_samp_r <= '0;
    end else begin
      prev_samp_r <= sync2_r;
    end
  end

  assign running = (acq_r != A_IDLE) && (acq_r != A_DRAIN);

  // internal sample strobe from the sample timebase, frozen while paused
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      samp_cnt_r <= '0;
      samp_int_r <= 1'b0;
    end else begin
      samp_int_r <= 1'b0;
      if (!running) begin
        samp_cnt_r <= i_cfg.samp_div;
      end else if (i_samp_tb_tick && !paused) begin
        if (samp_cnt_r <= 16'h0001) begin
          samp_int_r <= 1'b1;
          samp_cnt_r <= i_cfg.samp_div;
        end else begin
          samp_cnt_r <= samp_cnt_r - 16'h0001;
        end
      end
    end
  end

  assign samp_ev = i_cfg.shared ? conv_ext_ev
                 : (i_cfg.samp_src == SRC_INT) ? samp_int_r : samp_ext_ev;
  // sample strobes only count while running and between samples
  assign samp_acc = running && (cst_r == C_WAIT) && samp_ev;

  assign nchan = (i_cfg.num_chan == '0) ? 8'h01 : i_cfg.num_chan;
  assign conv_tb = i_cfg.conv_tb_20m ? i_tb20_tick : i_samp_tb_tick;
  assign conv_int = (i_cfg.conv_src == SRC_INT) && !i_cfg.shared;
  assign delay_eff = (i_cfg.conv_delay == '0) ? CONV_DELAY_DEF : i_cfg.conv_delay;
  assign int_fire = conv_tb && (cdiv_r <= 16'h0001);
  assign conv_fire = (cst_r == C_CONV) && (conv_int ? int_fire : conv_ext_ev)
                   || (samp_acc && i_cfg.shared);

  // per-sample conversion sequencer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cst_r <= C_WAIT;
      left_r <= '0;
      cdiv_r <= CONV_DELAY_DEF;
    end else begin
      unique case (cst_r)
        C_WAIT: begin
          cdiv_r <= delay_eff;
          if (samp_acc) begin
            left_r <= nchan;
            if (!(i_cfg.shared && nchan == 8'h01)) begin
              cst_r <= C_CONV;
            end
            if (i_cfg.shared) begin
              left_r <= nchan - 8'h01;
            end
          end
        end
        C_CONV: begin
          if (conv_int && conv_tb) begin
            cdiv_r <= int_fire ? i_cfg.conv_div : cdiv_r - 16'h0001;
          end
          if (conv_fire) begin
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01) begin
              cst_r <= C_WAIT;
            end
          end
        end
      endcase
    end
  end

  // conversion start, channel index and hold-done follow-up
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_conv_start <= 1'b0;
      o_chan <= '0;
      o_hold_done <= 1'b0;
    end else begin
      o_conv_start <= conv_fire;
      if (samp_acc) begin
        o_chan <= '0;
      end else if (o_conv_start) begin
        o_chan <= o_chan + 8'h01;
      end
      o_hold_done <= o_conv_start ^ i_cfg.hold_low;
    end
  end

  assign post_cnt = i_cfg.buffer_size - i_cfg.pretrig_count;

  // acquisition sequencer and sample counter
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acq_r <= A_IDLE;
      cnt_r <= '0;
      o_start_pulse <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_start_pulse <= 1'b0;
      o_done <= 1'b0;
      unique case (acq_r)
        A_IDLE: begin
          if (start_ev) begin
            o_start_pulse <= 1'b1;
            if (i_cfg.ref_en) begin
              cnt_r <= i_cfg.pretrig_count;
              acq_r <= (i_cfg.pretrig_count == '0) ? A_ARM : A_PRE;
            end else begin
              cnt_r <= i_cfg.sample_count;
              acq_r <= A_RUN;
            end
          end
        end
        A_RUN: begin
          if (samp_acc && !i_cfg.continuous) begin
            cnt_r <= cnt_r - 24'h000001;
            if (cnt_r <= 24'h000001) begin
              acq_r <= A_DRAIN;
            end
          end
        end
        A_PRE: begin
          if (samp_acc) begin
            cnt_r <= cnt_r - 24'h000001;
            if (cnt_r <= 24'h000001) begin
              acq_r <= A_ARM;
            end
          end
        end
        A_ARM: begin
          if (ref_ev) begin
            cnt_r <= post_cnt;
            acq_r <= (post_cnt == '0) ? A_DRAIN : A_POST;
          end
        end
        A_POST: begin
          if (samp_acc) begin
            cnt_r <= cnt_r - 24'h000001;
            if (cnt_r <= 24'h000001) begin
              acq_r <= A_DRAIN;
            end
          end
        end
        A_DRAIN: begin
          if (cst_r == C_WAIT) begin
            acq_r <= A_IDLE;
            o_done <= 1'b1;
          end
        end
      endcase
      if (i_sw_stop && running) begin
        acq_r <= A_DRAIN;
      end
    end
  end

  assign o_running = running;
  assign o_armed = (acq_r == A_ARM);

  // while armed and full, the oldest word is dropped to make room
  assign discard = (acq_r == A_ARM) && !fifo_full_n && fifo_valid && i_adc_valid;
  assign o_dout_valid = fifo_valid && !discard;

  actt_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_adc_valid),
    .i_in_data   (i_adc_data),
    .o_in_ready  (fifo_full_n),
    .o_out_valid (fifo_valid),
    .o_out_data  (o_dout_data),
    .i_out_ready (i_dout_ready || discard)
  );
  assign o_adc_ready = fifo_full_n;

  // pin drive; all enables low out of reset so every pin is an input
  for (genvar i = 0; i < NUM_LINE; i++) begin : g_pin
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        pin_oe_r[i] <= 1'b0;
        pin_out_r[i] <= 1'b0;
      end else begin
        pin_oe_r[i] <= (i_cfg.conv_route.en && i_cfg.conv_route.line == SEL_W'(i))
                     || (i_cfg.hold_route.en && i_cfg.hold_route.line == SEL_W'(i))
                     || (i_cfg.start_route.en && i_cfg.start_route.line == SEL_W'(i));
        if (i_cfg.conv_route.en && i_cfg.conv_route.line == SEL_W'(i)) begin
          pin_out_r[i] <= !o_conv_start;
        end else if (i_cfg.hold_route.en && i_cfg.hold_route.line == SEL_W'(i)) begin
          pin_out_r[i] <= o_hold_done;
        end else begin
          pin_out_r[i] <= o_start_pulse;
        end
      end
    end
  end

  assign o_fpin_out = pin_out_r[NUM_FPIN-1:0];
  assign o_fpin_oe = pin_oe_r[NUM_FPIN-1:0];
  assign o_sil_out = pin_out_r[NUM_LINE-1:NUM_FPIN];
  assign o_sil_oe = pin_oe_r[NUM_LINE-1:NUM_FPIN];
endmodule

// file: actt_pkg.sv
// constants and carrier types for the conversion trigger timing block
// assumes one synchronous clock domain; all pin inputs sampled on it
package actt_pkg;
  localparam int NUM_FPIN = 16;
  localparam int NUM_SIL  = 8;
  localparam int NUM_LINE = NUM_FPIN + NUM_SIL;
  localparam int NUM_SRC  = NUM_LINE + 3;
  localparam int CNT_W    = 24;
  localparam int CH_W     = 8;
  localparam int DIV_W    = 16;
  localparam int SEL_W    = 5;
  // source codes: 0..15 function pins, 16..23 integration lines
  localparam logic [SEL_W-1:0] SRC_STAR = 5'h18;
  localparam logic [SEL_W-1:0] SRC_ACMP = 5'h19;
  localparam logic [SEL_W-1:0] SRC_CTR  = 5'h1A;
  localparam logic [SEL_W-1:0] SRC_INT  = 5'h1B;
  localparam logic [SEL_W-1:0] SRC_SOFT = 5'h1F;
  localparam logic [DIV_W-1:0] CONV_DELAY_DEF = 16'h0003;
  localparam int FIFO_DEPTH_DEF = 32;

  typedef struct packed {
    logic             en;
    logic [SEL_W-1:0] line;
  } actt_route_type;

  typedef struct packed {
    logic [SEL_W-1:0] samp_src;
    logic             samp_rise;
    logic [DIV_W-1:0] samp_div;
    logic [SEL_W-1:0] conv_src;
    logic             conv_rise;
    logic             conv_tb_20m;
    logic [DIV_W-1:0] conv_div;
    logic [DIV_W-1:0] conv_delay;
    logic             shared;
    logic [CH_W-1:0]  num_chan;
    logic [SEL_W-1:0] start_src;
    logic             start_rise;
    logic             ref_en;
    logic [SEL_W-1:0] ref_src;
    logic             ref_rise;
    logic             pause_en;
    logic [SEL_W-1:0] pause_src;
    logic             pause_high;
    logic             continuous;
    logic [CNT_W-1:0] sample_count;
    logic [CNT_W-1:0] pretrig_count;
    logic [CNT_W-1:0] buffer_size;
    logic             hold_low;
    actt_route_type   conv_route;
    actt_route_type   hold_route;
    actt_route_type   start_route;
  } actt_cfg_type;
endpackage

// file: actt_monitor.sv
// port checker for the conversion trigger timing block
// assumes one clock domain and the synchronous reset on i_rst
`timescale 1ns/100ps
module actt_monitor import actt_pkg::*; #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  // watched ports
  input wire actt_cfg_type        i_cfg,
  input wire logic                i_dout_ready,
  input wire logic [NUM_FPIN-1:0] o_fpin_out,
  input wire logic [NUM_FPIN-1:0] o_fpin_oe,
  input wire logic [NUM_SIL-1:0]  o_sil_oe,
  input wire logic                o_conv_start,
  input wire logic [CH_W-1:0]     o_chan,
  input wire logic                o_hold_done,
  input wire logic                o_adc_ready,
  input wire logic                o_dout_valid,
  input wire logic [DATA_W-1:0]   o_dout_data,
  input wire logic                o_running,
  input wire logic                o_armed,
  input wire logic                o_start_pulse,
  input wire logic                o_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [CH_W-1:0] nch;
  // a zero channel count behaves as one channel
  assign nch = (i_cfg.num_chan == 8'h00) ? 8'h01 : i_cfg.num_chan;
  // the last sample's conversions may finish after o_running drops, so track start to done
  logic act_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      act_r <= 1'b0;
    end else if (o_start_pulse) begin
      act_r <= 1'b1;
    end else if (o_done) begin
      act_r <= 1'b0;
    end
  end
  a_hold_follows: assert property (o_conv_start |=> o_hold_done != i_cfg.hold_low)
    else $error("hold pulse missing after conversion");
  a_hold_cause: assert property (o_hold_done != i_cfg.hold_low && $stable(i_cfg.hold_low) |-> $past(o_conv_start))
    else $error("hold pulse without conversion");
  a_conv_gated: assert property (o_conv_start |-> act_r)
    else $error("conversion while idle");
  a_chan_range: assert property (o_conv_start |-> o_chan < nch)
    else $error("channel index out of range");
  a_pins_input: assert property ($past(i_rst) |-> o_fpin_oe == 16'h0000 && o_sil_oe == 8'h00)
    else $error("pin driven after reset");
  a_conv_pin_low: assert property (o_conv_start && i_cfg.conv_route.en && i_cfg.conv_route.line < 5'h10
    |=> o_fpin_oe[i_cfg.conv_route.line] && !o_fpin_out[i_cfg.conv_route.line])
    else $error("conversion strobe not driven low");
  a_start_pin_high: assert property (o_start_pulse && i_cfg.start_route.en && i_cfg.start_route.line < 5'h10
    |=> o_fpin_oe[i_cfg.start_route.line] && o_fpin_out[i_cfg.start_route.line])
    else $error("start pulse not driven high");
  a_start_once: assert property (o_start_pulse |=> !o_start_pulse ##1 o_running)
    else $error("start pulse malformed");
  a_done_ends: assert property (o_done |-> ##[0:1] !o_running)
    else $error("running after done");
  a_dout_hold: assert property (o_dout_valid && !i_dout_ready && !o_armed
    |=> o_dout_valid && $stable(o_dout_data))
    else $error("stream word lost while stalled");
  c_done: cover property (o_done);
  c_armed: cover property (o_armed);
  c_full: cover property (!o_adc_ready);
endmodule

bind actt_top actt_monitor #(.DATA_W(DATA_W)) u_mon (.i_core_clk, .i_rst, .i_cfg, .i_dout_ready,
  .o_fpin_out, .o_fpin_oe, .o_sil_oe, .o_conv_start, .o_chan, .o_hold_done, .o_adc_ready,
  .o_dout_valid, .o_dout_data, .o_running, .o_armed, .o_start_pulse, .o_done);

// file: actt_adc_model.sv
// behavioural converter: one result word per conversion start
// assumes results are pushed on the core clock
`timescale 1ns/100ps
module actt_adc_model #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // converter side
  input  wire logic        i_conv_start,
  input  wire logic        i_adc_ready,
  output logic             o_adc_valid,
  output logic [DATA_W-1:0] o_adc_data
);
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] seq_r;
  // results queue up so a stalled fifo never loses a conversion
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      q.delete();
      seq_r = '0;
      o_adc_valid <= 1'h0;
      o_adc_data <= '1;
    end else begin
      if (o_adc_valid && i_adc_ready) void'(q.pop_front());
      if (i_conv_start) begin
        q.push_back(seq_r);
        seq_r = seq_r + 1'h1;
      end
      o_adc_valid <= (q.size() != 0);
      // idle data keeps changing so a stale word is never mistaken for a result
      o_adc_data <= (q.size() != 0) ? q[0] : ~o_adc_data;
    end
  end
endmodule

// file: testbench.sv
// scenario testbench for the conversion trigger timing block
// assumes timebase ticks every cycle; checker attaches by bind
`timescale 1ns/100ps
module testbench import actt_pkg::*;;
  logic clk = 1'h0, rst = 1'h1, ss = 1'h0, sp = 1'h0, rdy = 1'h1, full_seen = 1'h0;
  actt_cfg_type c = '0;
  logic [15:0] fp = 16'h0000, fo, foe, dd, ad, seq = 16'h0000;
  logic [7:0] sl = 8'h00, so, soe, ch;
  logic cs, hd, av, ar, dv, run, arm, stp, dn;
  int failures = 0, checked = 0, nconv, nhold, ndone, npop;
  actt_top DUT (.i_core_clk(clk), .i_rst(rst), .i_cfg(c), .i_sw_start(ss), .i_sw_stop(sp),
    .i_fpin(fp), .i_sil(sl), .i_star(1'h0), .i_acmp(1'h0), .i_ctr_out(1'h0), .i_samp_tb_tick(1'h1),
    .i_tb20_tick(1'h1), .o_fpin_out(fo), .o_fpin_oe(foe), .o_sil_out(so), .o_sil_oe(soe),
    .o_conv_start(cs), .o_chan(ch), .o_hold_done(hd), .i_adc_valid(av), .i_adc_data(ad),
    .o_adc_ready(ar), .o_dout_valid(dv), .o_dout_data(dd), .i_dout_ready(rdy), .o_running(run),
    .o_armed(arm), .o_start_pulse(stp), .o_done(dn));
  actt_adc_model u_adc (.i_core_clk(clk), .i_rst(rst), .i_conv_start(cs), .i_adc_ready(ar),
    .o_adc_valid(av), .o_adc_data(ad));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (cs) nconv++;
    if (hd !== c.hold_low) nhold++;
    if (dn) ndone++;
    if (!rst && !ar) full_seen = 1'h1;
    if (dv && rdy) begin
      chk(dd, seq, "stream order");
      seq++;
      npop++;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic actt_cfg_type dflt();
    dflt = '0;
    dflt.samp_src = SRC_INT;
    dflt.conv_src = SRC_INT;
    dflt.samp_rise = 1'h1;
    dflt.conv_rise = 1'h1;
    dflt.conv_tb_20m = 1'h1;
    dflt.samp_div = 16'h0028;
    dflt.conv_div = 16'h0002;
    dflt.num_chan = 8'h01;
    dflt.start_src = SRC_SOFT;
    dflt.sample_count = 24'h000005;
    dflt.conv_route = '{1'h1, 5'h04};
    dflt.hold_route = '{1'h1, 5'h11};
    dflt.start_route = '{1'h1, 5'h09};
  endfunction
  task automatic setup(input actt_cfg_type t);
    @(posedge clk) c <= t;
    cyc(8);
    nconv = 0;
    nhold = 0;
    ndone = 0;
  endtask
  task automatic go(input bit stop);
    @(posedge clk) if (stop) sp <= 1'h1; else ss <= 1'h1;
    @(posedge clk) begin sp <= 1'h0; ss <= 1'h0; end
  endtask
  task automatic pulse(input int b);
    @(posedge clk) fp[b] <= ~fp[b];
    cyc(4);
    fp[b] <= ~fp[b];
    cyc(8);
  endtask
  task automatic wdone();
    for (int i = 0; i < 3000 && ndone == 0; i++) @(posedge clk);
    cyc(4);
  endtask
  task automatic t_idle();
    actt_cfg_type t = dflt();
    t.samp_src = 5'h00;
    t.conv_src = 5'h01;
    setup(t);
    pulse(0);
    pulse(1);
    chk(nconv, 0, "strobes while idle");
    chk(run, 0, "running while idle");
    $display("idle test done");
  endtask
  task automatic t_fifo();
    actt_cfg_type t = dflt();
    t.num_chan = 8'h08;
    setup(t);
    @(posedge clk) rdy <= 1'h0;
    npop = 0;
    go(0);
    wdone();
    chk(nconv, 40, "conversions");
    chk(nhold, 40, "hold pulses");
    chk(ndone, 1, "finite end");
    chk(full_seen, 1, "fifo refused");
    chk(soe[1], 1, "hold line driven");
    rdy <= 1'h1;
    cyc(80);
    chk(npop, 40, "words drained");
    chk(dv, 0, "fifo empty");
    $display("finite fifo test done");
  endtask
  task automatic t_gate();
    actt_cfg_type t = dflt();
    t.samp_src = 5'h00;
    t.conv_src = 5'h01;
    t.conv_rise = 1'h0;
    t.num_chan = 8'h02;
    t.sample_count = 24'h000002;
    @(posedge clk) fp <= 16'h0002;
    setup(t);
    go(0);
    pulse(1);
    pulse(0);
    pulse(0);
    repeat (3) pulse(1);
    pulse(0);
    repeat (2) pulse(1);
    wdone();
    chk(nconv, 4, "gated conversions");
    chk(ndone, 1, "two samples end");
    fp <= 16'h0000;
    $display("gating test done");
  endtask
  task automatic t_shared();
    actt_cfg_type t = dflt();
    t.samp_src = 5'h02;
    t.conv_src = 5'h02;
    t.shared = 1'h1;
    t.num_chan = 8'h03;
    t.sample_count = 24'h000002;
    t.hold_low = 1'h1;
    setup(t);
    go(0);
    repeat (6) pulse(2);
    wdone();
    chk(nconv, 6, "shared conversions");
    chk(nhold, 6, "low hold pulses");
    $display("shared test done");
  endtask
  task automatic t_start();
    actt_cfg_type t = dflt();
    t.start_src = 5'h13;
    t.start_rise = 1'h0;
    t.continuous = 1'h1;
    @(posedge clk) sl <= 8'hFF;
    setup(t);
    chk(run, 0, "rising edge ignored");
    @(posedge clk) sl[3] <= 1'h0;
    cyc(100);
    chk(run, 1, "falling edge starts");
    chk(nconv > 0, 1, "continuous sampling");
    go(1);
    cyc(6);
    chk(ndone, 1, "software stop");
    chk(run, 0, "stopped");
    sl <= 8'h00;
    $display("start stop test done");
  endtask
  task automatic t_pause();
    actt_cfg_type t = dflt();
    t.continuous = 1'h1;
    t.pause_en = 1'h1;
    t.pause_src = 5'h07;
    t.pause_high = 1'h1;
    @(posedge clk) fp <= 16'h0080;
    setup(t);
    go(0);
    cyc(200);
    chk(nconv, 0, "paused");
    fp <= 16'h0000;
    cyc(200);
    chk(nconv >= 3, 1, "resumed");
    go(1);
    cyc(6);
    $display("pause test done");
  endtask
  task automatic t_ref();
    actt_cfg_type t = dflt();
    t.ref_en = 1'h1;
    t.ref_src = 5'h05;
    t.ref_rise = 1'h1;
    t.pretrig_count = 24'h000002;
    t.buffer_size = 24'h000005;
    t.sample_count = 24'h000064;
    setup(t);
    go(0);
    cyc(10);
    pulse(5);
    for (int i = 0; i < 500 && nconv < 3; i++) @(posedge clk);
    cyc(10);
    chk(arm, 1, "armed after pretrigger");
    pulse(5);
    nconv = 0;
    wdone();
    chk(nconv, 3, "posttrigger samples");
    chk(ndone, 1, "reference stop");
    $display("reference test done");
  endtask
  task automatic end_sim();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    cyc(8);
    rst <= 1'h0;
    cyc(4);
    chk(foe, 0, "pins input after reset");
    chk(soe, 0, "lines input after reset");
    t_idle();
    t_fifo();
    t_gate();
    t_shared();
    t_start();
    t_pause();
    t_ref();
    end_sim();
  end
endmodule
